// >>> design/fwh_target_bus_port.sv
`timescale 1ns/10ps
`include "fwh_port_map.svh"

// Summary of operation
// - Sample each bus nibble on rising clock edge
// - Start nibble 1101 reads, 1110 writes
// - Seven address nibbles follow, most significant first
// - Decode only low address bits per part size
// - Address bit 22 selects array or registers
// - Upper address bits other than bit 22 are ignored
// - Respond only when ID nibble matches straps
// - Size nibble must be zero, single byte
// - Read: host turns bus, device drives clock 12
// - Read: ready nibble zero in clock 13
// - Data byte low nibble first, then high
// - Device drives ones clock 16, then floats
// - Write: data 11-12, turnaround, ready in 15
// - Frame mid-cycle aborts; release after 1111
// - Abort never disturbs running program or erase
// - Only reset or init stops the engine
// - Unlock sequences accepted; chip erase rejected
// - Init returns to standby, bus floats
module fwh_target_bus_port
    import fwh_port_pkg::*;
#(
    parameter int ADDR_BITS = `FWH_SMALL_ADDR_BITS
) (
    input wire logic REF_CLK_IN,          // bus clock
    input wire logic RST_B_IN,            // async reset, active low
    input wire logic FRAME_B_IN,          // cycle_frame, active low
    input wire logic [3:0] NIB_IN,        // host_nibble_bus level in
    input wire logic [3:0] CHIP_ID_IN,    // chip_id_straps
    input wire logic INIT_B_IN,           // init pin, active low
    input wire logic [7:0] MEM_RDATA_IN,  // read data from array/registers
    input wire logic ENGINE_BUSY_IN,      // program/erase engine busy
    output logic [3:0] NIB_OUT,           // host_nibble_bus drive value
    output logic NIB_OE_OUT,              // high while driving the bus
    output logic MEM_REQ_VALID_OUT,       // one-cycle request pulse
    output mem_req_t MEM_REQ_OUT,         // request fields
    output logic CMD_VALID_OUT,           // one-cycle command pulse
    output cmd_t CMD_OUT,                 // decoded engine command
    output logic ENGINE_RESET_OUT         // stops program/erase engine
);

    localparam logic [18:0] ADDR_MASK = 19'((20'h1 << ADDR_BITS) - 20'h1);

    bus_state_t st_q;
    prot_state_t ps_q;
    logic [2:0] cnt_q;
    logic is_wr_q;
    logic [27:0] addr_q;
    logic [3:0] wlo_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic arr_wr_q;
    logic [3:0] nib_q;
    logic oe_q;
    logic mem_valid_q;
    mem_req_t mem_req_q;
    logic cmd_valid_q;
    cmd_t cmd_q;
    logic engine_rst_q;
    logic [2:0] init_s_q;
    logic init_q;
    logic [3:0] id_s1_q;
    logic [3:0] id_s2_q;
    logic [3:0] id_s3_q;
    logic [3:0] id_q;
    logic frame_low;
    logic in_cycle;
    logic [18:0] dec_addr;
    logic [14:0] ua;

    assign frame_low = !FRAME_B_IN;
    assign in_cycle = (st_q == ST_ID) || (st_q == ST_ADDR) || (st_q == ST_SIZE) || (st_q == ST_WDATA) ||
                      (st_q == ST_TARIN) || (st_q == ST_SYNC) || (st_q == ST_RDATA);
    assign dec_addr = addr_q[18:0] & ADDR_MASK;
    assign ua = addr_q[14:0];

    // Init pin is asynchronous; a change counts once stages two and three agree
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            init_s_q <= 3'h7;
            init_q <= 1'b0;
        end else begin
            init_s_q <= {init_s_q[1:0], INIT_B_IN};
            if (init_s_q[1] == init_s_q[2]) begin
                init_q <= !init_s_q[2];
            end
        end
    end

    // Straps are caught after reset release, never loaded by the reset itself
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            id_s1_q <= 4'h0;
            id_s2_q <= 4'h0;
            id_s3_q <= 4'h0;
            id_q <= 4'h0;
        end else begin
            id_s1_q <= CHIP_ID_IN;
            id_s2_q <= id_s1_q;
            id_s3_q <= id_s2_q;
            if (id_s2_q == id_s3_q) begin
                id_q <= id_s3_q;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            engine_rst_q <= 1'b1;
        end else begin
            engine_rst_q <= init_q;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
            is_wr_q <= 1'b0;
            addr_q <= 28'h0;
            wlo_q <= 4'h0;
            wdata_q <= 8'h0;
            rdata_q <= 8'h0;
            arr_wr_q <= 1'b0;
            nib_q <= `FWH_TURN_NIB;
            oe_q <= 1'b0;
            mem_valid_q <= 1'b0;
            mem_req_q <= '0;
        end else begin
            mem_valid_q <= 1'b0;
            arr_wr_q <= 1'b0;
            if (init_q) begin
                st_q <= ST_IDLE;
                oe_q <= 1'b0;
                nib_q <= `FWH_TURN_NIB;
            end else if (frame_low && in_cycle) begin
                // end cycle; hold bus until abort nibble
                nib_q <= `FWH_TURN_NIB;
                if (NIB_IN == `FWH_ABORT_NIB) begin
                    st_q <= ST_IDLE;
                    oe_q <= 1'b0;
                end else begin
                    st_q <= ST_ABORT;
                end
            end else begin
                unique case (st_q)
                    ST_IDLE, ST_IGNORE: begin
                        if (frame_low && (NIB_IN == `FWH_START_READ || NIB_IN == `FWH_START_WRITE)) begin
                            st_q <= ST_ID;
                            is_wr_q <= (NIB_IN == `FWH_START_WRITE);
                        end
                    end
                    ST_ID: begin
                        cnt_q <= 3'h0;
                        st_q <= (NIB_IN == id_q) ? ST_ADDR : ST_IGNORE;
                    end
                    ST_ADDR: begin
                        addr_q <= {addr_q[23:0], NIB_IN};
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == `FWH_ADDR_LAST) begin
                            st_q <= ST_SIZE;
                        end
                    end
                    ST_SIZE: begin
                        cnt_q <= 3'h0;
                        if (NIB_IN != `FWH_SIZE_ONE_BYTE) begin
                            st_q <= ST_IGNORE;
                        end else if (is_wr_q) begin
                            st_q <= ST_WDATA;
                        end else begin
                            st_q <= ST_TARIN;
                            mem_valid_q <= 1'b1;
                            mem_req_q <= '{wr: 1'b0, array_sel: addr_q[`FWH_ARRAY_SEL_BIT], addr: dec_addr,
                                           data: 8'h0};
                        end
                    end
                    ST_WDATA: begin
                        if (cnt_q == 3'h0) begin
                            wlo_q <= NIB_IN;
                            cnt_q <= 3'h1;
                        end else begin
                            wdata_q <= {NIB_IN, wlo_q};
                            cnt_q <= 3'h0;
                            st_q <= ST_TARIN;
                            // array writes feed the unlock decoder
                            if (addr_q[`FWH_ARRAY_SEL_BIT]) begin
                                arr_wr_q <= 1'b1;
                            end else begin
                                mem_valid_q <= 1'b1;
                                mem_req_q <= '{wr: 1'b1, array_sel: 1'b0, addr: dec_addr, data: {NIB_IN, wlo_q}};
                            end
                        end
                    end
                    ST_TARIN: begin
                        if (cnt_q == 3'h0) begin
                            oe_q <= 1'b1;
                            nib_q <= `FWH_TURN_NIB;
                            cnt_q <= 3'h1;
                        end else begin
                            nib_q <= `FWH_READY_NIB;
                            rdata_q <= MEM_RDATA_IN;
                            cnt_q <= 3'h0;
                            st_q <= ST_SYNC;
                        end
                    end
                    ST_SYNC: begin
                        if (is_wr_q) begin
                            nib_q <= `FWH_TURN_NIB;
                            st_q <= ST_TAROUT;
                        end else begin
                            nib_q <= rdata_q[3:0];
                            st_q <= ST_RDATA;
                        end
                    end
                    ST_RDATA: begin
                        if (cnt_q == 3'h0) begin
                            nib_q <= rdata_q[7:4];
                            cnt_q <= 3'h1;
                        end else begin
                            nib_q <= `FWH_TURN_NIB;
                            cnt_q <= 3'h0;
                            st_q <= ST_TAROUT;
                        end
                    end
                    ST_TAROUT: begin
                        oe_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                    ST_ABORT: begin
                        if (frame_low && NIB_IN == `FWH_ABORT_NIB) begin
                            oe_q <= 1'b0;
                            st_q <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Unlock decoder; writes are ignored while the engine runs
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ps_q <= PS_IDLE;
            cmd_valid_q <= 1'b0;
            cmd_q <= '{kind: CMD_NONE, addr: 19'h0, data: 8'h0};
        end else begin
            cmd_valid_q <= 1'b0;
            if (init_q) begin
                ps_q <= PS_IDLE;
            end else if (arr_wr_q && !ENGINE_BUSY_IN) begin
                cmd_q.addr <= dec_addr;
                cmd_q.data <= wdata_q;
                ps_q <= PS_IDLE;
                // accepted sequences; anything else back to idle
                unique case (ps_q)
                    PS_IDLE: begin
                        if (wdata_q == `FWH_OP_ID_EXIT) begin
                            cmd_valid_q <= 1'b1;
                            cmd_q.kind <= CMD_ID_EXIT;
                        end else if (ua == `FWH_UNLOCK_ADDR1 && wdata_q == `FWH_UNLOCK_DATA1) begin
                            ps_q <= PS_U1;
                        end
                    end
                    PS_U1, PS_E_U1: begin
                        if (ua == `FWH_UNLOCK_ADDR2 && wdata_q == `FWH_UNLOCK_DATA2) begin
                            ps_q <= (ps_q == PS_U1) ? PS_CMD : PS_E_CMD;
                        end
                    end
                    PS_CMD: begin
                        if (ua == `FWH_UNLOCK_ADDR1) begin
                            if (wdata_q == `FWH_OP_PROGRAM) begin
                                ps_q <= PS_PGM;
                            end else if (wdata_q == `FWH_OP_ERASE_SETUP) begin
                                ps_q <= PS_E_U0;
                            end else if (wdata_q == `FWH_OP_ID_ENTRY) begin
                                cmd_valid_q <= 1'b1;
                                cmd_q.kind <= CMD_ID_ENTRY;
                            end
                        end
                    end
                    PS_PGM: begin
                        cmd_valid_q <= 1'b1;
                        cmd_q.kind <= CMD_PROGRAM;
                    end
                    PS_E_U0: begin
                        if (ua == `FWH_UNLOCK_ADDR1 && wdata_q == `FWH_UNLOCK_DATA1) begin
                            ps_q <= PS_E_U1;
                        end
                    end
                    PS_E_CMD: begin
                        if (wdata_q == `FWH_OP_SECTOR_ERASE) begin
                            cmd_valid_q <= 1'b1;
                            cmd_q.kind <= CMD_SECTOR_ERASE;
                        end else if (wdata_q == `FWH_OP_BLOCK_ERASE) begin
                            cmd_valid_q <= 1'b1;
                            cmd_q.kind <= CMD_BLOCK_ERASE;
                        end
                    end
                endcase
            end
        end
    end

    assign NIB_OUT = nib_q;
    assign NIB_OE_OUT = oe_q;
    assign MEM_REQ_VALID_OUT = mem_valid_q;
    assign MEM_REQ_OUT = mem_req_q;
    assign CMD_VALID_OUT = cmd_valid_q;
    assign CMD_OUT = cmd_q;
    assign ENGINE_RESET_OUT = engine_rst_q;

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    start_decode_a: assert property (st_q == ST_IDLE && !init_q && frame_low && NIB_IN == `FWH_START_READ
        |=> st_q == ST_ID && !is_wr_q) else $error("read start not decoded");
    addr_shift_a: assert property (st_q == ST_ADDR && !init_q && !frame_low
        |=> addr_q[3:0] == $past(NIB_IN) && addr_q[7:4] == $past(addr_q[3:0])) else $error("address nibble lost");
    addr_len_a: assert property ($rose(st_q == ST_SIZE) |-> $past(st_q == ST_ADDR, 7))
        else $error("address phase not seven clocks");
    id_match_a: assert property (st_q == ST_ID && !init_q && !frame_low && NIB_IN != id_q
        |=> st_q == ST_IGNORE) else $error("foreign ID accepted");
    size_check_a: assert property (st_q == ST_SIZE && !init_q && !frame_low && NIB_IN != 4'h0
        |=> st_q == ST_IGNORE) else $error("multi-byte size accepted");
    quiet_bus_a: assert property (st_q == ST_IGNORE |-> !oe_q) else $error("driven while ignoring");
    read_turn_a: assert property (st_q == ST_TARIN && cnt_q == 3'h0 && !is_wr_q && !init_q && !frame_low
        |=> oe_q && nib_q == 4'hf ##1 (oe_q && nib_q == 4'h0 || st_q != ST_SYNC)) else $error("read turnaround");
    ready_sync_a: assert property (st_q == ST_SYNC |-> oe_q && nib_q == 4'h0) else $error("no ready nibble");
    data_order_a: assert property (st_q == ST_RDATA && cnt_q == 3'h1
        |-> nib_q == rdata_q[7:4] && $past(nib_q) == rdata_q[3:0]) else $error("data nibble order");
    release_a: assert property (st_q == ST_TAROUT && !init_q |-> oe_q && nib_q == 4'hf ##1 !oe_q)
        else $error("bus not released");
    abort_hold_a: assert property (st_q == ST_ABORT && !init_q && !(frame_low && NIB_IN == 4'hf)
        |=> st_q == ST_ABORT && oe_q == $past(oe_q)) else $error("abort left early");
    abort_engine_a: assert property (st_q == ST_ABORT && !init_q |-> !engine_rst_q)
        else $error("abort stopped engine");
    init_float_a: assert property (init_q |=> !oe_q && st_q == ST_IDLE && engine_rst_q)
        else $error("init did not reach standby");
    route_a: assert property (mem_valid_q && mem_req_q.wr |-> !mem_req_q.array_sel
        && (mem_req_q.addr & ~ADDR_MASK) == 19'h0) else $error("array write routed to registers");
    chip_erase_a: assert property (ps_q == PS_E_CMD && arr_wr_q && !init_q && wdata_q == 8'h10
        && !ENGINE_BUSY_IN |=> !cmd_valid_q && ps_q == PS_IDLE) else $error("chip erase accepted");
    read_done_c: cover property (st_q == ST_RDATA ##1 st_q == ST_TAROUT ##1 st_q == ST_IDLE);
    write_done_c: cover property (st_q == ST_SYNC && is_wr_q ##1 st_q == ST_TAROUT);
    abort_c: cover property (st_q == ST_ABORT && oe_q ##1 st_q == ST_IDLE);
    program_c: cover property (cmd_valid_q && cmd_q.kind == CMD_PROGRAM);

endmodule

// >>> pkg/fwh_port_map.svh
`ifndef FWH_PORT_MAP_SVH
`define FWH_PORT_MAP_SVH

// Start nibbles, abort nibble and fixed field values on the nibble bus
`define FWH_START_READ 4'hd
`define FWH_START_WRITE 4'he
`define FWH_ABORT_NIB 4'hf
`define FWH_SIZE_ONE_BYTE 4'h0
`define FWH_READY_NIB 4'h0
`define FWH_TURN_NIB 4'hf

// Address layout
`define FWH_ADDR_NIBBLES 3'd7
`define FWH_ADDR_LAST 3'd6
`define FWH_ARRAY_SEL_BIT 22
`define FWH_DEC_W 19
`define FWH_SMALL_ADDR_BITS 18

// Unlock sequence addresses (low 15 bits) and data
`define FWH_UNLOCK_ADDR1 15'h5555
`define FWH_UNLOCK_ADDR2 15'h2aaa
`define FWH_UNLOCK_DATA1 8'haa
`define FWH_UNLOCK_DATA2 8'h55
`define FWH_OP_PROGRAM 8'ha0
`define FWH_OP_ID_ENTRY 8'h90
`define FWH_OP_ID_EXIT 8'hf0
`define FWH_OP_ERASE_SETUP 8'h80
`define FWH_OP_SECTOR_ERASE 8'h30
`define FWH_OP_BLOCK_ERASE 8'h50
`define FWH_OP_CHIP_ERASE 8'h10

`endif

// >>> pkg/fwh_port_pkg.sv
package fwh_port_pkg;

    typedef enum logic [10:0] {
        ST_IDLE   = 11'h001,
        ST_ID     = 11'h002,
        ST_ADDR   = 11'h004,
        ST_SIZE   = 11'h008,
        ST_WDATA  = 11'h010,
        ST_TARIN  = 11'h020,
        ST_SYNC   = 11'h040,
        ST_RDATA  = 11'h080,
        ST_TAROUT = 11'h100,
        ST_ABORT  = 11'h200,
        ST_IGNORE = 11'h400
    } bus_state_t;

    typedef enum logic [6:0] {
        PS_IDLE  = 7'h01,
        PS_U1    = 7'h02,
        PS_CMD   = 7'h04,
        PS_PGM   = 7'h08,
        PS_E_U0  = 7'h10,
        PS_E_U1  = 7'h20,
        PS_E_CMD = 7'h40
    } prot_state_t;

    typedef enum logic [2:0] {
        CMD_NONE         = 3'h0,
        CMD_PROGRAM      = 3'h1,
        CMD_SECTOR_ERASE = 3'h2,
        CMD_BLOCK_ERASE  = 3'h3,
        CMD_ID_ENTRY     = 3'h4,
        CMD_ID_EXIT      = 3'h5
    } cmd_kind_t;

    typedef struct packed {
        logic wr;
        logic array_sel;
        logic [18:0] addr;
        logic [7:0] data;
    } mem_req_t;

    typedef struct packed {
        cmd_kind_t kind;
        logic [18:0] addr;
        logic [7:0] data;
    } cmd_t;

endpackage

// >>> bench/fwh_host_model.sv
`timescale 1ns/10ps
module fwh_host_model (
    input wire logic clk_in,           // bus clock
    input wire logic [3:0] dev_nib_in, // device drive value
    input wire logic dev_oe_in,        // device drives bus
    output logic frame_b_out,          // cycle_frame, active low
    output logic [3:0] bus_out,        // resolved bus level
    output logic resp_vld_out,         // one pulse per finished cycle
    output logic [24:0] resp_out       // drive count, nibbles of clocks 12 to 16
);
    logic host_oe = 1'b1;
    logic [3:0] host_nib = 4'hf;
    logic [3:0] float_q = 4'h0;
    initial begin
        frame_b_out = 1'b1;
        resp_vld_out = 1'b0;
        resp_out = 25'h0;
    end
    // Released lines wander so a stale nibble never passes for a driven one
    always @(posedge clk_in) begin
        float_q <= float_q + 4'h7;
    end
    assign bus_out = host_oe ? host_nib : (dev_oe_in ? dev_nib_in : float_q);
    // one cycle; nonzero ab_k aborts there
    task automatic cycle(input logic [3:0] st, input logic [3:0] id, input logic [27:0] a,
                         input logic [3:0] sz, input logic [7:0] d, input int ab_k, input logic [3:0] ab_n);
        logic [4:0] cnt;
        logic [19:0] nibs;
        logic wr;
        cnt = 5'h0;
        nibs = 20'h0;
        wr = (st == 4'he);
        for (int k = 1; k <= 17; k++) begin
            @(posedge clk_in);
            #1;
            host_oe = 1'b1;
            host_nib = 4'hf;
            frame_b_out = (k != 1);
            // frame again in the next clock with the 1111 nibble, unless ab_n was already 1111
            if (ab_k != 0 && k >= ab_k) begin
                frame_b_out = !(k == ab_k || (k == ab_k + 1 && ab_n != 4'hf));
                host_nib = (k == ab_k) ? ab_n : 4'hf;
            end else begin
                case (k)
                    1: host_nib = st;
                    2: host_nib = id;
                    3, 4, 5, 6, 7, 8, 9: host_nib = 4'(a >> (4 * (9 - k)));
                    10: host_nib = sz;
                    11: host_nib = wr ? d[3:0] : 4'hf;
                    12: host_nib = d[7:4];
                    default: host_nib = 4'hf;
                endcase
                // release at turnaround, take back in clock 17
                host_oe = !(k >= (wr ? 14 : 12) && k <= 16);
            end
            cnt = cnt + 5'(dev_oe_in);
            if (k >= 12 && k <= 16 && dev_oe_in) nibs[4 * (16 - k) +: 4] = dev_nib_in;
        end
        resp_out = {cnt, nibs};
        resp_vld_out = 1'b1;
        @(posedge clk_in);
        #1;
        resp_vld_out = 1'b0;
    endtask
endmodule

// >>> bench/fwh_target_bus_port_tb.sv
`timescale 1ns/10ps
module fwh_target_bus_port_tb;
    import fwh_port_pkg::*;
    localparam int AB = 18;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic init_b = 1'b1;
    logic busy = 1'b0;
    logic skip = 1'b0;
    logic [7:0] rdata = 8'h0;
    logic [3:0] straps;
    logic [31:0] seed = 32'h1a;
    logic frame_b, oe, req_vld, cmd_vld, eng_rst, resp_vld;
    logic [3:0] bus, dnib;
    logic [24:0] resp;
    mem_req_t req;
    cmd_t cmd;
    mem_req_t mq[$];
    cmd_t cq[$];
    logic [24:0] bq[$];
    int errors = 0;
    int compares = 0;

    always #5 clk = ~clk;

    fwh_target_bus_port #(.ADDR_BITS(AB)) uut (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .FRAME_B_IN(frame_b),
        .NIB_IN(bus), .CHIP_ID_IN(straps), .INIT_B_IN(init_b), .MEM_RDATA_IN(rdata), .ENGINE_BUSY_IN(busy),
        .NIB_OUT(dnib), .NIB_OE_OUT(oe), .MEM_REQ_VALID_OUT(req_vld), .MEM_REQ_OUT(req),
        .CMD_VALID_OUT(cmd_vld), .CMD_OUT(cmd), .ENGINE_RESET_OUT(eng_rst));
    fwh_host_model host (.clk_in(clk), .dev_nib_in(dnib), .dev_oe_in(oe), .frame_b_out(frame_b),
        .bus_out(bus), .resp_vld_out(resp_vld), .resp_out(resp));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [18:0] dec(input logic [27:0] a);
        return 19'(a[AB-1:0]);
    endfunction
    // Bits outside the decode are random; s lands on the space select bit
    function automatic logic [27:0] at(input logic s, input logic [17:0] lo);
        return (28'(rnd()) & 28'hfbc0000) | {5'h0, s, 22'h0} | 28'(lo);
    endfunction
    function automatic cmd_kind_t kind(input logic [7:0] op);
        case (op)
            8'ha0: return CMD_PROGRAM;
            8'h90: return CMD_ID_ENTRY;
            8'hf0: return CMD_ID_EXIT;
            8'h30: return CMD_SECTOR_ERASE;
            default: return CMD_BLOCK_ERASE;
        endcase
    endfunction

    task automatic fail(input string what, input logic [31:0] e, input logic [31:0] g);
        errors++;
        $display("Error %s expected %h seen %h", what, e, g);
    endtask
    task automatic chk_mem(input mem_req_t e, input mem_req_t g);
        compares++;
        if (!e.wr) g.data = e.data;
        if (g !== e) fail("mem_req", 32'(e), 32'(g));
    endtask
    task automatic chk_cmd(input cmd_t e, input cmd_t g);
        compares++;
        if (g !== e) fail("cmd", 32'(e), 32'(g));
    endtask
    task automatic chk_resp(input logic [24:0] e, input logic [24:0] g);
        compares++;
        if (g !== e) fail("bus_nibbles", 32'(e), 32'(g));
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        compares++;
        if (g !== e) fail(what, 32'(e), 32'(g));
    endtask

    task automatic rd(input logic [27:0] a);
        rdata = 8'(rnd());
        mq.push_back(mem_req_t'{1'b0, a[22], dec(a), 8'h0});
        bq.push_back({5'd5, 4'hf, 4'h0, rdata[3:0], rdata[7:4], 4'hf});
        host.cycle(4'hd, straps, a, 4'h0, 8'h0, 0, 4'h0);
    endtask
    task automatic wr(input logic [27:0] a, input logic [7:0] d);
        if (!a[22]) mq.push_back(mem_req_t'{1'b1, 1'b0, dec(a), d});
        bq.push_back({5'd3, 20'h00f0f});
        host.cycle(4'he, straps, a, 4'h0, d, 0, 4'h0);
    endtask
    task automatic ign(input logic [3:0] st, input logic [3:0] id, input logic [3:0] sz);
        bq.push_back(25'h0);
        host.cycle(st, id, at(1'b0, 18'h01234), sz, 8'h5a, 0, 4'h0);
    endtask
    task automatic unl();
        wr(at(1'b1, 18'h05555), 8'haa);
        wr(at(1'b1, 18'h02aaa), 8'h55);
    endtask

    task results();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(negedge clk) begin
        if (req_vld === 1'b1) begin
            if (mq.size() == 0) fail("mem_req", 32'h0, 32'(req));
            else chk_mem(mq.pop_front(), req);
        end
        if (cmd_vld === 1'b1) begin
            if (cq.size() == 0) fail("cmd", 32'h0, 32'(cmd));
            else chk_cmd(cq.pop_front(), cmd);
        end
        if (resp_vld === 1'b1 && !skip) begin
            if (bq.size() == 0) fail("bus_nibbles", 32'h0, 32'(resp));
            else chk_resp(bq.pop_front(), resp);
        end
    end

    initial begin
        repeat (8000) @(posedge clk);
        errors++;
        results();
    end

    initial begin
        logic [7:0] ops[6];
        logic [27:0] a;
        logic [7:0] d;
        ops = '{8'ha0, 8'h90, 8'hf0, 8'h30, 8'h50, 8'h10};
        straps = 4'(rnd());
        repeat (16) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk_bit("engine_reset", 1'b0, eng_rst);
        for (int i = 0; i < 8; i++) begin
            a = at(i[0], 18'(rnd()));
            rd(a);
            if (i < 4) wr(at(1'b0, 18'(rnd())), 8'(rnd()));
        end
        for (int s = 0; s < 13; s++) ign(4'(s), straps, 4'h0);
        ign(4'hd, straps ^ 4'h1, 4'h0);
        ign(4'he, ~straps, 4'h0);
        ign(4'hd, straps, 4'h1);
        ign(4'he, straps, 4'h8);
        // each unlock sequence, chip erase refused
        foreach (ops[i]) begin
            d = 8'(rnd());
            a = at(1'b1, 18'(rnd()));
            if (ops[i] != 8'hf0) unl();
            if (ops[i] inside {8'h30, 8'h50, 8'h10}) begin
                wr(at(1'b1, 18'h05555), 8'h80);
                unl();
                d = ops[i];
            end else if (ops[i] == 8'ha0) begin
                wr(at(1'b1, 18'h05555), 8'ha0);
            end else begin
                a = at(1'b1, 18'h05555);
                d = ops[i];
            end
            if (ops[i] != 8'h10) cq.push_back(cmd_t'{kind(ops[i]), dec(a), d});
            wr(a, d);
        end
        // Busy engine and a broken sequence start nothing
        busy = 1'b1;
        unl();
        wr(at(1'b1, 18'h05555), 8'ha0);
        wr(at(1'b1, 18'h00100), 8'h12);
        busy = 1'b0;
        wr(at(1'b1, 18'h05555), 8'haa);
        wr(at(1'b1, 18'h02aaa), 8'h54);
        wr(at(1'b1, 18'h05555), 8'ha0);
        wr(at(1'b1, 18'h00100), 8'h12);
        // early abort, prompt 1111, late 1111
        busy = 1'b1;
        a = at(1'b1, 18'h00abc);
        bq.push_back(25'h0);
        host.cycle(4'he, straps, a, 4'h0, 8'h33, 5, 4'hf);
        mq.push_back(mem_req_t'{1'b0, 1'b1, dec(a), 8'h0});
        bq.push_back({5'd2, 4'hf, 16'h0});
        host.cycle(4'hd, straps, a, 4'h0, 8'h0, 13, 4'hf);
        rdata = 8'(rnd());
        mq.push_back(mem_req_t'{1'b0, 1'b1, dec(a), 8'h0});
        bq.push_back({5'd4, 4'hf, 4'h0, rdata[3:0], 4'hf, 4'h0});
        host.cycle(4'hd, straps, a, 4'h0, 8'h0, 14, 4'h0);
        chk_bit("engine_reset", 1'b0, eng_rst);
        rd(a);
        skip = 1'b1;
        mq.push_back(mem_req_t'{1'b0, 1'b1, dec(a), 8'h0});
        fork
            host.cycle(4'hd, straps, a, 4'h0, 8'h0, 0, 4'h0);
            begin
                repeat (9) @(posedge clk);
                #1;
                init_b = 1'b0;
                for (int n = 0; n < 8 && eng_rst !== 1'b1; n++) @(negedge clk);
                @(posedge clk);
                #1;
                chk_bit("engine_reset", 1'b1, eng_rst);
                chk_bit("bus_enable", 1'b0, oe);
            end
        join
        init_b = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        skip = 1'b0;
        chk_bit("engine_reset", 1'b0, eng_rst);
        busy = 1'b0;
        rd(at(1'b0, 18'h3ffff));
        repeat (4) @(posedge clk);
        chk_bit("queues_empty", 1'b1, mq.size() == 0 && cq.size() == 0 && bq.size() == 0);
        results();
    end
endmodule
